/* File: rtl/lane_error_count_status.sv */
// Purpose: Read-only lane error tally and power state status bank
// Assumes: Management port decoder delivers one-cycle read and write strobes
// Notes:   Read data appears one clock after the read strobe
//
// Summary of operation
// RQ1 - Lane 0 bits 11:8 at 19h, low nibble
// RQ2 - Lane 1 tally at 1Ah byte, 1Bh nibble
// RQ3 - Lane 2 tally at 1Ch byte, 1Dh nibble
// RQ4 - Lane 3 tally at 1Eh byte, 1Fh nibble
// RQ5 - Tallies hardware updated, host writes ignored
// RQ6 - Bit 7 at 20h shows power-down
// RQ7 - Lane 0 bits 7:0 at 18h
// RQ8 - Rising edge of clear zeroes all tallies
// RQ9 - Selector picks source; count only when enabled
// RQ10 - Bit 6 at 20h shows standby
// RQ11 - Tallies saturate at all ones, never wrap
`include "lane_error_defines.svh"
`default_nettype none
module lane_error_count_status #(
	parameter int LANES   = `LEC_LANES,
	parameter int TALLY_W = `LEC_TALLY_W
) (
	input  wire logic                       clock,
	input  wire logic                       arst_n,
	input  wire lane_error_pkg::csr_req_s   csr_req,
	input  wire lane_error_pkg::count_ctrl_s count_ctrl,
	input  wire lane_error_pkg::lane_events_s lane_events,
	input  wire logic                       powered_down,
	input  wire logic                       standby,
	output logic [`LEC_DATA_W-1:0]          read_data_reg,
	output logic                            read_valid_reg,
	output logic [LANES*TALLY_W-1:0]        lane_error_tally_reg
);
	import lane_error_pkg::*;

	// Refuse shapes that the fixed address map cannot hold
	if (LANES != `LEC_LANES) begin : g_bad_lanes
		$error("lane_error_count_status: map serves exactly four lanes");
	end
	if (TALLY_W != `LEC_TALLY_W) begin : g_bad_width
		$error("lane_error_count_status: map serves 12-bit tallies only");
	end
	// A tally must split into one byte and one nibble exactly
	if (TALLY_W != `LEC_DATA_W + 4) begin : g_bad_split
		$error("lane_error_count_status: tally does not fit byte plus nibble");
	end

	// Saturating increment so a burst never reads back as a small count
	function automatic tally_t tally_step(input tally_t cur, input logic hit);
		if (hit && cur != {TALLY_W{1'b1}}) begin // see RQ11
			return cur + tally_t'(1);
		end
		return cur;
	endfunction

	// Byte for a lane: low selects bits 7:0, else bits 11:8 with zero top
	function automatic logic [7:0] tally_byte(input tally_t t, input logic hi);
		if (hi) begin
			return {4'h0, t[11:8]};
		end
		return t[7:0];
	endfunction

	// Address compare shared by every location of the bank
	function automatic logic loc_match(input logic [`LEC_ADDR_W-1:0] a, input logic [`LEC_ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	logic                  clear_seen_reg;
	logic                  clear_rise;
	logic [LANES-1:0]      lane_hit;
	logic [LANES-1:0]      src_events;
	tally_t                tally_reg  [LANES];
	tally_t                tally_next [LANES];
	logic [7:0]            status_byte;
	logic [7:0]            read_mux;
	logic [7:0]            read_data_next;
	logic                  read_strobe;

	// Selector decode, one line per source code
	logic                  use_disparity;
	logic                  use_fifo;
	logic                  use_overflow;
	logic                  use_underflow;
	logic                  use_deskew;

	// Location decode, one line per byte of the bank
	logic                  sel_lane0_lo;
	logic                  sel_lane0_hi;
	logic                  sel_lane1_lo;
	logic                  sel_lane1_hi;
	logic                  sel_lane2_lo;
	logic                  sel_lane2_hi;
	logic                  sel_lane3_lo;
	logic                  sel_lane3_hi;
	logic                  sel_power;
	logic                  sel_unmapped;

	// Byte each tally location would answer with
	logic [7:0]            byte_lane0_lo;
	logic [7:0]            byte_lane0_hi;
	logic [7:0]            byte_lane1_lo;
	logic [7:0]            byte_lane1_hi;
	logic [7:0]            byte_lane2_lo;
	logic [7:0]            byte_lane2_hi;
	logic [7:0]            byte_lane3_lo;
	logic [7:0]            byte_lane3_hi;

	// Edge detect of the clear control; a held level clears only once
	assign clear_rise = count_ctrl.tally_clear & ~clear_seen_reg; // see RQ8

	// Selector decode; reserved codes leave every line low and count nothing
	assign use_disparity = count_ctrl.error_source_select == `LEC_SRC_DISPARITY; // see RQ9
	assign use_fifo      = count_ctrl.error_source_select == `LEC_SRC_FIFO; // see RQ9
	assign use_overflow  = count_ctrl.error_source_select == `LEC_SRC_OVERFLOW; // see RQ9
	assign use_underflow = count_ctrl.error_source_select == `LEC_SRC_UNDERFLOW; // see RQ9
	assign use_deskew    = count_ctrl.error_source_select == `LEC_SRC_DESKEW; // see RQ9

	// At most one decode line is high, so an OR of gated sources is the mux
	assign src_events = ({LANES{use_disparity}} & lane_events.disparity)
		| ({LANES{use_fifo}} & lane_events.fifo)
		| ({LANES{use_overflow}} & lane_events.overflow)
		| ({LANES{use_underflow}} & lane_events.underflow)
		| ({LANES{use_deskew}} & lane_events.deskew); // see RQ9
	assign lane_hit = src_events & count_ctrl.lane_check_enable; // see RQ9

	// Next tally per lane; clear wins over a same-cycle error
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			// Clear edge first, then a saturating step on a counted hit
			assign tally_next[g] = clear_rise ? `LEC_RESET_TALLY
				: tally_step(tally_reg[g], lane_hit[g]); // see RQ8
			assign lane_error_tally_reg[g*TALLY_W +: TALLY_W] = tally_reg[g];
		end
	endgenerate

	// Tallies move only from the datapath; csr writes never reach them
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			clear_seen_reg <= 1'b0;
			for (int i = 0; i < LANES; i++) begin
				tally_reg[i] <= `LEC_RESET_TALLY;
			end
		end else begin
			clear_seen_reg <= count_ctrl.tally_clear;
			for (int i = 0; i < LANES; i++) begin
				tally_reg[i] <= tally_next[i]; // see RQ5
			end
		end
	end

	// Power state byte; other bits belong elsewhere and read zero here
	always_comb begin
		status_byte                        = `LEC_RESET_BYTE;
		status_byte[`LEC_POWERED_DOWN_BIT] = powered_down; // see RQ6
		status_byte[`LEC_STANDBY_BIT]      = standby; // see RQ10
	end

	// Location decode from the management address
	assign sel_lane0_lo = loc_match(csr_req.addr, `LEC_OFS_LANE0_LO); // see RQ7
	assign sel_lane0_hi = loc_match(csr_req.addr, `LEC_OFS_LANE0_HI); // see RQ1
	assign sel_lane1_lo = loc_match(csr_req.addr, `LEC_OFS_LANE1_LO); // see RQ2
	assign sel_lane1_hi = loc_match(csr_req.addr, `LEC_OFS_LANE1_HI); // see RQ2
	assign sel_lane2_lo = loc_match(csr_req.addr, `LEC_OFS_LANE2_LO); // see RQ3
	assign sel_lane2_hi = loc_match(csr_req.addr, `LEC_OFS_LANE2_HI); // see RQ3
	assign sel_lane3_lo = loc_match(csr_req.addr, `LEC_OFS_LANE3_LO); // see RQ4
	assign sel_lane3_hi = loc_match(csr_req.addr, `LEC_OFS_LANE3_HI); // see RQ4
	assign sel_power    = loc_match(csr_req.addr, `LEC_OFS_POWER_STATE); // see RQ6 see RQ10
	assign sel_unmapped = ~|{sel_lane0_lo, sel_lane0_hi, sel_lane1_lo, sel_lane1_hi,
		sel_lane2_lo, sel_lane2_hi, sel_lane3_lo, sel_lane3_hi, sel_power};

	// High locations carry a zero top nibble, so reads never show stray bits
	assign byte_lane0_lo = tally_byte(tally_reg[0], 1'b0); // see RQ7
	assign byte_lane0_hi = tally_byte(tally_reg[0], 1'b1); // see RQ1
	assign byte_lane1_lo = tally_byte(tally_reg[1], 1'b0); // see RQ2
	assign byte_lane1_hi = tally_byte(tally_reg[1], 1'b1); // see RQ2
	assign byte_lane2_lo = tally_byte(tally_reg[2], 1'b0); // see RQ3
	assign byte_lane2_hi = tally_byte(tally_reg[2], 1'b1); // see RQ3
	assign byte_lane3_lo = tally_byte(tally_reg[3], 1'b0); // see RQ4
	assign byte_lane3_hi = tally_byte(tally_reg[3], 1'b1); // see RQ4

	// Decode lines are one-hot, so the mux is an OR of gated bytes
	assign read_mux = ({8{sel_lane0_lo}} & byte_lane0_lo)
		| ({8{sel_lane0_hi}} & byte_lane0_hi)
		| ({8{sel_lane1_lo}} & byte_lane1_lo)
		| ({8{sel_lane1_hi}} & byte_lane1_hi)
		| ({8{sel_lane2_lo}} & byte_lane2_lo)
		| ({8{sel_lane2_hi}} & byte_lane2_hi)
		| ({8{sel_lane3_lo}} & byte_lane3_lo)
		| ({8{sel_lane3_hi}} & byte_lane3_hi)
		| ({8{sel_power}} & status_byte)
		| ({8{sel_unmapped}} & `LEC_UNMAPPED_BYTE);

	// Read strobe alone decides; a write in the same cycle is still a read
	assign read_strobe = csr_req.rd;

	// Data holds between reads so a slow serializer can take it late
	assign read_data_next = read_strobe ? read_mux : read_data_reg;

	// Read answer registers; write strobe deliberately unused for storage
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			read_data_reg  <= `LEC_RESET_BYTE;
			read_valid_reg <= 1'b0;
		end else begin
			read_data_reg  <= read_data_next;
			read_valid_reg <= read_strobe;
		end
	end

endmodule
`default_nettype wire

/* File: common/lane_error_defines.svh */
// Purpose: Offsets, field positions, reset values and codes of the lane error status bank
// Assumes: Byte-wide locations on the device's management port
// Notes:   Definitions only
`ifndef LANE_ERROR_DEFINES_SVH
`define LANE_ERROR_DEFINES_SVH

`define LEC_ADDR_W            8
`define LEC_DATA_W            8
`define LEC_TALLY_W           12
`define LEC_LANES             4
`define LEC_SEL_W             3

`define LEC_OFS_LANE0_LO      8'h18
`define LEC_OFS_LANE0_HI      8'h19
`define LEC_OFS_LANE1_LO      8'h1a
`define LEC_OFS_LANE1_HI      8'h1b
`define LEC_OFS_LANE2_LO      8'h1c
`define LEC_OFS_LANE2_HI      8'h1d
`define LEC_OFS_LANE3_LO      8'h1e
`define LEC_OFS_LANE3_HI      8'h1f
`define LEC_OFS_POWER_STATE   8'h20

`define LEC_POWERED_DOWN_BIT  7
`define LEC_STANDBY_BIT       6
`define LEC_RESET_BYTE        8'h00
`define LEC_RESET_TALLY       12'h000
`define LEC_UNMAPPED_BYTE     8'h00

`define LEC_SRC_DISPARITY     3'h0
`define LEC_SRC_FIFO          3'h1
`define LEC_SRC_OVERFLOW      3'h2
`define LEC_SRC_UNDERFLOW     3'h3
`define LEC_SRC_DESKEW        3'h4

`endif

/* File: common/lane_error_pkg.sv */
// Purpose: Types shared by the lane error status bank and its users
// Assumes: lane_error_defines.svh supplies the widths
// Notes:   Structs carry grouped signals
`include "lane_error_defines.svh"
`default_nettype none
package lane_error_pkg;

	// One bit per lane for each error source
	typedef struct packed {
		logic [`LEC_LANES-1:0] disparity;
		logic [`LEC_LANES-1:0] fifo;
		logic [`LEC_LANES-1:0] overflow;
		logic [`LEC_LANES-1:0] underflow;
		logic [`LEC_LANES-1:0] deskew;
	} lane_events_s;

	// One register access from the management port
	typedef struct packed {
		logic                   rd;
		logic                   wr;
		logic [`LEC_ADDR_W-1:0] addr;
		logic [`LEC_DATA_W-1:0] wdata;
	} csr_req_s;

	// Counting controls owned by the setup registers
	typedef struct packed {
		logic                   tally_clear;
		logic [`LEC_SEL_W-1:0]  error_source_select;
		logic [`LEC_LANES-1:0]  lane_check_enable;
	} count_ctrl_s;

	typedef logic [`LEC_TALLY_W-1:0] tally_t;

endpackage
`default_nettype wire

/* File: testbench/lane_error_monitor.sv */
// Purpose: Port assertions for the status bank
// Assumes: Answer one clock after rd
// Notes:   Bound from the bench top
`default_nettype none
module lane_error_monitor (
	input wire logic                        clock,
	input wire logic                        arst_n,
	input wire lane_error_pkg::csr_req_s    csr_req,
	input wire lane_error_pkg::count_ctrl_s count_ctrl,
	input wire logic                        powered_down,
	input wire logic                        standby,
	input wire logic [7:0]                  read_data_reg,
	input wire logic                        read_valid_reg,
	input wire logic [47:0]                 lane_error_tally_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	a_rd_answer: assert property (
		csr_req.rd |=> read_valid_reg) else $error("no read answer");
	a_no_stray: assert property (
		!csr_req.rd |=> !read_valid_reg) else $error("stray read answer");
	a_lane0_low: assert property (
		csr_req.rd && csr_req.addr == 8'h18 |=> read_data_reg == $past(lane_error_tally_reg[7:0])) else $error("18 bad");
	a_lane1_high: assert property (
		csr_req.rd && csr_req.addr == 8'h1b |=> read_data_reg == {4'h0, $past(lane_error_tally_reg[23:20])})
		else $error("1b bad");
	a_power_bits: assert property (
		csr_req.rd && csr_req.addr == 8'h20 |=> read_data_reg == {$past(powered_down), $past(standby), 6'h00})
		else $error("20 bad");
	a_clear_edge: assert property (
		$rose(count_ctrl.tally_clear) |=> lane_error_tally_reg == 48'h0) else $error("clear missed");
	a_tally_sat: assert property (
		lane_error_tally_reg[11:0] == 12'hfff && !count_ctrl.tally_clear |=> lane_error_tally_reg[11:0] == 12'hfff)
		else $error("tally wrapped");
	a_lane_off: assert property (
		!count_ctrl.lane_check_enable[3] && !count_ctrl.tally_clear |=> $stable(lane_error_tally_reg[47:36]))
		else $error("disabled lane moved");
endmodule
`default_nettype wire

/* File: testbench/host_model.sv */
// Purpose: Host issuing management accesses
// Assumes: Answer lands one clock after the strobe
// Notes:   Strobe spans exactly one rising edge
`default_nettype none
module host_model (
	input  wire logic                     clock,
	output var lane_error_pkg::csr_req_s  csr_req,
	input  wire logic [7:0]               read_data_reg,
	input  wire logic                     read_valid_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	initial csr_req = '0;
	// Data taken only with valid, so a missing answer shows as unknown
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] q);
		@(negedge clock) csr_req <= '{rd: !wr, wr: wr, addr: a, wdata: wd};
		@(negedge clock) csr_req <= '0;
		q = read_valid_reg ? read_data_reg : 8'hxx;
	endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the status bank
// Assumes: Inputs move on the falling edge
// Notes:   Saturation run is about 4100 cycles
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import lane_error_pkg::*;
	logic        clock = 1'b0, arst_n = 1'b0, powered_down = 1'b0, standby = 1'b0;
	csr_req_s    csr_req;
	count_ctrl_s count_ctrl = '0;
	lane_events_s lane_events = '0;
	logic [7:0]  read_data_reg, q;
	logic        read_valid_reg;
	logic [47:0] tally;
	int          errors = 0, n_checks = 0, cycles = 0;
	always #25 clock = ~clock;
	lane_error_count_status i_dut (.clock, .arst_n, .csr_req, .count_ctrl, .lane_events, .powered_down, .standby,
		.read_data_reg, .read_valid_reg, .lane_error_tally_reg(tally));
	host_model i_host (.clock, .csr_req, .read_data_reg, .read_valid_reg);
	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] exp);
		i_host.access(1'b0, a, 8'h00, q);
		check("read", {4'h0, exp}, {4'h0, q});
	endtask
	// Holds an event pattern for n rising edges
	task automatic hits(input lane_events_s ev, input int n);
		@(negedge clock) lane_events <= ev;
		repeat (n) @(negedge clock);
		lane_events <= '0;
	endtask
	// Hang guard, well above the expected run
	always @(posedge clock) begin
		cycles++;
		if (cycles > 20000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (4) @(negedge clock);
		arst_n <= 1'b1;
		for (int a = 8'h18; a <= 8'h21; a++) rd_exp(8'(a), 8'h00);
		for (int a = 8'h18; a <= 8'h20; a++) i_host.access(1'b1, 8'(a), 8'hff, q);
		rd_exp(8'h1a, 8'h00);
		count_ctrl.lane_check_enable <= 4'b0111;
		hits('{disparity: 4'b1101, default: 4'h0}, 3);
		rd_exp(8'h18, 8'h03);
		rd_exp(8'h1c, 8'h03);
		rd_exp(8'h1e, 8'h00);
		// Every selector code on lane 0; reserved codes see all sources high
		for (int s = 0; s < 8; s++) begin
			count_ctrl.error_source_select <= 3'(s);
			hits(s < 5 ? lane_events_s'(20'h10000 >> (4 * s)) : lane_events_s'(20'hfffff), 1);
			check("tally0", 12'(s < 5 ? 4 + s : 8), tally[11:0]);
		end
		count_ctrl.error_source_select <= 3'h0;
		hits('{disparity: 4'h1, default: 4'h0}, 4100);
		rd_exp(8'h19, 8'h0f);
		rd_exp(8'h18, 8'hff);
		count_ctrl.tally_clear <= 1'b1;
		hits('{disparity: 4'h1, default: 4'h0}, 2);
		check("tally0", 12'h002, tally[11:0]);
		count_ctrl.tally_clear <= 1'b0;
		// Lanes 1 to 3 past one byte, so every high nibble reads non-zero
		count_ctrl.lane_check_enable <= 4'b1111;
		hits('{disparity: 4'b1110, default: 4'h0}, 258);
		check("tally1", 12'h102, tally[23:12]);
		for (int a = 0; a < 6; a++) rd_exp(8'(8'h1a + a), a[0] ? 8'h01 : 8'h02);
		// Reset in mid-run drops every tally back to zero
		arst_n <= 1'b0;
		repeat (2) @(negedge clock);
		arst_n <= 1'b1;
		check("tally3", 12'h000, tally[47:36]);
		rd_exp(8'h1f, 8'h00);
		powered_down <= 1'b1;
		standby <= 1'b1;
		rd_exp(8'h20, 8'hc0);
		powered_down <= 1'b0;
		rd_exp(8'h20, 8'h40);
		print_verdict();
	end
endmodule
bind lane_error_count_status lane_error_monitor i_mon (.clock, .arst_n, .csr_req, .count_ctrl, .powered_down,
	.standby, .read_data_reg, .read_valid_reg, .lane_error_tally_reg);
`default_nettype wire
